// ==== inc/gpp_defs.svh ====
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH

// port-form register byte offsets
`define GPP_OFS_OUTVAL 8'h00
`define GPP_OFS_PINSTATE 8'h04
`define GPP_OFS_DRVSEL0 8'h08
`define GPP_OFS_DRVSEL1 8'h0c
`define GPP_OFS_DRVSEL2 8'h10
`define GPP_OFS_SLEW 8'h14
`define GPP_OFS_BIDIR 8'h18
`define GPP_OFS_INDIS 8'h1c
`define GPP_OFS_REGHI 8'h20
`define GPP_OFS_CTRL 8'h24
`define GPP_OFS_OESEL 8'h28
`define GPP_OFS_INTTYPE 8'h2c
`define GPP_OFS_INTSTAT 8'h30
// pin-form registers: base plus four bytes per pin
`define GPP_OFS_PINFORM 8'h40
`define GPP_PINFORM_LAST 8'h5c

// pin-form field positions
`define GPP_PF_OUTVAL 0
`define GPP_PF_DRV0 1
`define GPP_PF_DRV1 2
`define GPP_PF_DRV2 3
`define GPP_PF_SLEW 4
`define GPP_PF_BIDIR 5
`define GPP_PF_INDIS 6
`define GPP_PF_STATE 7

// control register field positions
`define GPP_CTRL_LVTTL 0
`define GPP_CTRL_USBMODE 1

// reset values
`define GPP_RST_BYTE 8'h00
`define GPP_RST_OESEL 32'h0000_0000
`define GPP_RST_INTTYPE 16'h0000

// first usb-capable pin on a usb port
`define GPP_USB_PIN_LO 6

`endif

// ==== inc/gpp_pkg.sv ====
package gpp_pkg;

    typedef enum logic [2:0] {
        GPP_DM_HIZ_ANALOG = 3'b000,
        GPP_DM_HIZ_DIGITAL = 3'b001,
        GPP_DM_RES_UP = 3'b010,
        GPP_DM_RES_DOWN = 3'b011,
        GPP_DM_OD_LOW = 3'b100,
        GPP_DM_OD_HIGH = 3'b101,
        GPP_DM_STRONG = 3'b110,
        GPP_DM_RES_BOTH = 3'b111
    } gpp_drive_t;

    typedef enum logic [1:0] {
        GPP_INT_OFF = 2'b00,
        GPP_INT_RISE = 2'b01,
        GPP_INT_FALL = 2'b10,
        GPP_INT_BOTH = 2'b11
    } gpp_int_t;

    typedef enum logic [1:0] {
        GPP_KIND_GPIO = 2'b00,
        GPP_KIND_SIO = 2'b01,
        GPP_KIND_USB = 2'b10
    } gpp_kind_t;

    // per-pin pad control; strong drive is oe with out as level
    typedef struct packed {
        logic oe;
        logic out;
        logic pu;
        logic pd;
        logic ie;
        logic slow;
        logic reg_hi;
    } gpp_pad_t;

endpackage

// ==== rtl/gpp_port.sv ====
//Contract
//- code 0: driver and input buffer off
//- code 1: input on, output high impedance
//- codes 2,3: resistive one side, strong other
//- codes 4,5: open drain low / high
//- code 6: strong both ways
//- code 7: resistive high and low
//- regulated special pin: no resistive drive
//- usb pin drive and pull enables
//- usb mode ignores bits; port drive writes spare them
//- port form and pin form share storage
//- bidirectional: output enable switches drive
//- sixteen aux output enables, any pin
//- per-pin slew, strong and open drain only
//- one interrupt unit and vector per port
//- edge select rising falling both off
//- edge sets status bit, raises request
//- edge detection keeps running in sleep
//- no level-sensitive detection here
//- port-wide cmos or lvttl threshold
//- per-pin input buffer disable
//- special pin regulated output high select
//- three drive bits form select code
//- separate pin state and output registers
//- reset holds pins high impedance analog
`timescale 1ns/1ps
`include "gpp_defs.svh"
`default_nettype none

module gpp_port #(
    parameter gpp_pkg::gpp_kind_t KIND = gpp_pkg::GPP_KIND_GPIO
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic [7:0] pad_in, // pin levels
    input wire logic [15:0] aux_oe, // auxiliary output enables
    output gpp_pkg::gpp_pad_t [7:0] pad_ctl, // pad controls
    output logic port_lvttl, // input threshold select
    output logic usb_handover, // usb pins owned by usb core
    output logic port_irq // interrupt request
);
    import gpp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // storage

    logic [7:0] outval_q, drv0_q, drv1_q, drv2_q, slew_q, bidir_q, indis_q;
    logic [7:0] reghi_q, intstat_q, state_q, sync1_q, sync2_q, prev_q;
    logic [1:0] ctrl_q;
    logic [31:0] oesel_q;
    logic [15:0] inttype_q;
    logic ready_q, err_q, irq_q;
    logic [31:0] rdata_q;
    gpp_pad_t [7:0] pad_q;

    ////////////////////////////////////////////////////////////////////////
    // functions

    function automatic gpp_pad_t drive_decode(input logic [2:0] code,
                                              input logic dr,
                                              input logic no_res);
        gpp_pad_t p;
        p = '0;
        p.out = dr;
        // only code 0 turns the input buffer off
        p.ie = (code != 3'b000);
        unique case (gpp_drive_t'(code))
            GPP_DM_HIZ_ANALOG, GPP_DM_HIZ_DIGITAL: ;
            GPP_DM_RES_UP: begin
                p.oe = ~dr;
                p.pu = dr;
            end
            GPP_DM_RES_DOWN: begin
                p.oe = dr;
                p.pd = ~dr;
            end
            GPP_DM_OD_LOW: p.oe = ~dr;
            GPP_DM_OD_HIGH: p.oe = dr;
            GPP_DM_STRONG: p.oe = 1'b1;
            GPP_DM_RES_BOTH: begin
                p.pu = dr;
                p.pd = ~dr;
            end
        endcase
        // slew applies to strong and open drain modes only
        p.slow = code[2] & ~(code[1] & code[0]);
        if (no_res) begin
            p.pu = 1'b0;
            p.pd = 1'b0;
        end
        return p;
    endfunction

    function automatic logic edge_hit(input logic [1:0] typ,
                                      input logic now, input logic was);
        // edges only; a steady level never matches
        return (typ[0] & now & ~was) | (typ[1] & ~now & was);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    logic setup, wr, rd, pf_hit, mapped, usb_port;
    logic [2:0] pf_idx;
    logic [7:0] port_keep;

    assign setup = psel & ~penable;
    assign wr = psel & penable & ready_q & pwrite & ~err_q;
    assign rd = psel & penable & ready_q & ~pwrite & ~err_q;
    assign pf_hit = paddr >= `GPP_OFS_PINFORM && paddr <= `GPP_PINFORM_LAST
                    && paddr[1:0] == 2'b00;
    assign pf_idx = paddr[4:2];
    assign usb_port = KIND == GPP_KIND_USB;
    // port-form drive writes never touch the usb pins' bits
    assign port_keep = usb_port ? 8'hc0 : 8'h00;

    always_comb begin
        unique case (paddr)
            `GPP_OFS_OUTVAL, `GPP_OFS_PINSTATE, `GPP_OFS_DRVSEL0,
            `GPP_OFS_DRVSEL1, `GPP_OFS_DRVSEL2, `GPP_OFS_SLEW,
            `GPP_OFS_BIDIR, `GPP_OFS_INDIS, `GPP_OFS_REGHI,
            `GPP_OFS_CTRL, `GPP_OFS_OESEL, `GPP_OFS_INTTYPE,
            `GPP_OFS_INTSTAT: mapped = 1'b1;
            default: mapped = pf_hit;
        endcase
    end

    // zero wait states: answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ready_q <= setup;
            err_q <= setup & ~mapped;
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (pf_hit) begin
            rd_mux[`GPP_PF_OUTVAL] = outval_q[pf_idx];
            rd_mux[`GPP_PF_DRV0] = drv0_q[pf_idx];
            rd_mux[`GPP_PF_DRV1] = drv1_q[pf_idx];
            rd_mux[`GPP_PF_DRV2] = drv2_q[pf_idx];
            rd_mux[`GPP_PF_SLEW] = slew_q[pf_idx];
            rd_mux[`GPP_PF_BIDIR] = bidir_q[pf_idx];
            rd_mux[`GPP_PF_INDIS] = indis_q[pf_idx];
            rd_mux[`GPP_PF_STATE] = state_q[pf_idx];
        end else begin
            unique case (paddr)
                `GPP_OFS_OUTVAL: rd_mux[7:0] = outval_q;
                `GPP_OFS_PINSTATE: rd_mux[7:0] = state_q;
                `GPP_OFS_DRVSEL0: rd_mux[7:0] = drv0_q;
                `GPP_OFS_DRVSEL1: rd_mux[7:0] = drv1_q;
                `GPP_OFS_DRVSEL2: rd_mux[7:0] = drv2_q;
                `GPP_OFS_SLEW: rd_mux[7:0] = slew_q;
                `GPP_OFS_BIDIR: rd_mux[7:0] = bidir_q;
                `GPP_OFS_INDIS: rd_mux[7:0] = indis_q;
                `GPP_OFS_REGHI: rd_mux[7:0] = reghi_q;
                `GPP_OFS_CTRL: rd_mux[1:0] = ctrl_q;
                `GPP_OFS_OESEL: rd_mux = oesel_q;
                `GPP_OFS_INTTYPE: rd_mux[15:0] = inttype_q;
                `GPP_OFS_INTSTAT: rd_mux[7:0] = intstat_q;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup) begin
            rdata_q <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            outval_q <= `GPP_RST_BYTE;
            drv0_q <= `GPP_RST_BYTE;
            drv1_q <= `GPP_RST_BYTE;
            drv2_q <= `GPP_RST_BYTE;
            slew_q <= `GPP_RST_BYTE;
            bidir_q <= `GPP_RST_BYTE;
            indis_q <= `GPP_RST_BYTE;
        end else if (wr && pf_hit) begin
            outval_q[pf_idx] <= pwdata[`GPP_PF_OUTVAL];
            drv0_q[pf_idx] <= pwdata[`GPP_PF_DRV0];
            drv1_q[pf_idx] <= pwdata[`GPP_PF_DRV1];
            drv2_q[pf_idx] <= pwdata[`GPP_PF_DRV2];
            slew_q[pf_idx] <= pwdata[`GPP_PF_SLEW];
            bidir_q[pf_idx] <= pwdata[`GPP_PF_BIDIR];
            indis_q[pf_idx] <= pwdata[`GPP_PF_INDIS];
        end else if (wr) begin
            unique case (paddr)
                `GPP_OFS_OUTVAL: outval_q <= pwdata[7:0];
                `GPP_OFS_DRVSEL0:
                    drv0_q <= (drv0_q & port_keep) |
                              (pwdata[7:0] & ~port_keep);
                `GPP_OFS_DRVSEL1:
                    drv1_q <= (drv1_q & port_keep) |
                              (pwdata[7:0] & ~port_keep);
                `GPP_OFS_DRVSEL2:
                    drv2_q <= (drv2_q & port_keep) |
                              (pwdata[7:0] & ~port_keep);
                `GPP_OFS_SLEW: slew_q <= pwdata[7:0];
                `GPP_OFS_BIDIR: bidir_q <= pwdata[7:0];
                `GPP_OFS_INDIS: indis_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reghi_q <= `GPP_RST_BYTE;
            ctrl_q <= 2'b00;
            oesel_q <= `GPP_RST_OESEL;
            inttype_q <= `GPP_RST_INTTYPE;
        end else if (wr && !pf_hit) begin
            unique case (paddr)
                `GPP_OFS_REGHI: begin
                    // only special pins have a regulated high
                    if (KIND == GPP_KIND_SIO) begin
                        reghi_q <= pwdata[7:0];
                    end
                end
                `GPP_OFS_CTRL: begin
                    ctrl_q[`GPP_CTRL_LVTTL] <=
                        pwdata[`GPP_CTRL_LVTTL];
                    ctrl_q[`GPP_CTRL_USBMODE] <=
                        pwdata[`GPP_CTRL_USBMODE] & usb_port;
                end
                `GPP_OFS_OESEL: oesel_q <= pwdata;
                `GPP_OFS_INTTYPE: inttype_q <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pad drive

    gpp_pad_t [7:0] pad_d;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad_d[i] = drive_decode({drv2_q[i], drv1_q[i], drv0_q[i]},
                                    outval_q[i],
                                    reghi_q[i]);
            pad_d[i].reg_hi = reghi_q[i];
            pad_d[i].slow = pad_d[i].slow & slew_q[i];
            if (bidir_q[i] && !aux_oe[oesel_q[4*i +: 4]]) begin
                // output disabled: high impedance digital input
                pad_d[i].oe = 1'b0;
                pad_d[i].pu = 1'b0;
                pad_d[i].pd = 1'b0;
                pad_d[i].ie = 1'b1;
                pad_d[i].slow = 1'b0;
            end
            if (usb_port && i >= `GPP_USB_PIN_LO) begin
                pad_d[i] = '0;
                pad_d[i].out = outval_q[i];
                if (!ctrl_q[`GPP_CTRL_USBMODE]) begin
                    pad_d[i].ie = 1'b1;
                    pad_d[i].oe = drv0_q[i] | ~outval_q[i];
                    pad_d[i].pu = ~drv0_q[i] & drv1_q[i] & outval_q[i];
                end
            end
            if (indis_q[i]) begin
                pad_d[i].ie = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_q <= '0;
        end else begin
            pad_q <= pad_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input path and interrupt unit

    // runs on the free clock with no sleep gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            prev_q <= 8'h00;
            state_q <= 8'h00;
        end else begin
            sync1_q <= pad_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            for (int i = 0; i < 8; i++) begin
                state_q[i] <= sync2_q[i] & pad_q[i].ie;
            end
        end
    end

    logic [7:0] hit;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            hit[i] = edge_hit(inttype_q[2*i +: 2], sync2_q[i],
                              prev_q[i]);
        end
    end

    // a new edge wins over the read that clears its bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            intstat_q <= 8'h00;
        end else begin
            if (rd && paddr == `GPP_OFS_INTSTAT) begin
                intstat_q <= (intstat_q & ~rdata_q[7:0]) | hit;
            end else begin
                intstat_q <= intstat_q | hit;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |intstat_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign pad_ctl = pad_q;
    assign port_lvttl = ctrl_q[`GPP_CTRL_LVTTL];
    assign usb_handover = ctrl_q[`GPP_CTRL_USBMODE];
    assign port_irq = irq_q;

endmodule

`default_nettype wire

// ==== bench/gpp_port_sva.sv ====
`timescale 1ns/1ps
`include "gpp_defs.svh"
`default_nettype none
module gpp_port_sva #(
    parameter gpp_pkg::gpp_kind_t KIND = gpp_pkg::GPP_KIND_GPIO
) (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pwrite, // direction
    input wire logic [7:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic [7:0] pad_in, // pin levels
    input wire logic [15:0] aux_oe, // output enables
    input wire gpp_pkg::gpp_pad_t [7:0] pad_ctl, // pad controls
    input wire logic port_lvttl, // threshold
    input wire logic usb_handover, // usb mode
    input wire logic port_irq // request
);
    import gpp_pkg::*;
    logic rd_int, wr, usb;
    logic [7:0] fight, slow_res;
    assign rd_int = psel && penable && !pwrite && paddr == `GPP_OFS_INTSTAT;
    assign wr = psel && penable && pwrite && pready;
    assign usb = KIND == GPP_KIND_USB;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            fight[i] = pad_ctl[i].oe && (pad_ctl[i].pu || pad_ctl[i].pd);
            slow_res[i] = pad_ctl[i].slow && (pad_ctl[i].pu || pad_ctl[i].pd);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    AST_RST_PADS:
    assert property ($rose(presetn) |-> pad_ctl == '0 && !port_irq)
        else $error("pads not idle after reset");
    AST_READY_NEXT:
    assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_READY_ONE:
    assert property (pready |-> psel && penable && !$past(pready))
        else $error("ready outside one access cycle");
    AST_MAPPED_OK:
    assert property (pready && paddr <= 8'h30 && paddr[1:0] == 2'h0 |->
        !pslverr) else $error("error on mapped register");
    AST_NO_FIGHT:
    assert property (fight == 8'h00) else $error("strong drive with pull");
    AST_SLEW_RES:
    assert property (slow_res == 8'h00) else $error("slew on resistive pin");
    AST_USB_OFF:
    assert property (usb && usb_handover && $past(usb_handover) |->
        (pad_ctl[7] & 7'h5f) == 7'h00 && (pad_ctl[6] & 7'h5f) == 7'h00)
        else $error("usb pin driven in usb mode");
    AST_USB_LOW:
    assert property (usb && !usb_handover && !$past(usb_handover) &&
        $past(presetn) && !pad_ctl[`GPP_USB_PIN_LO].out |->
        pad_ctl[`GPP_USB_PIN_LO].oe) else $error("usb pin not driving low");
    AST_IRQ_HOLD:
    assert property (port_irq && !rd_int && !$past(rd_int) |=> port_irq)
        else $error("request dropped without read");
    AST_PAD_CAUSE:
    assert property ($changed(pad_ctl) && $past(presetn, 2) |->
        $past(wr) || $past(wr, 2) || $past(aux_oe) != $past(aux_oe, 2))
        else $error("pad change without cause");
endmodule
bind gpp_port gpp_port_sva #(.KIND(KIND)) gpp_port_sva_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .aux_oe(aux_oe),
    .pad_ctl(pad_ctl), .port_lvttl(port_lvttl),
    .usb_handover(usb_handover), .port_irq(port_irq)
);
`default_nettype wire

// ==== bench/gpp_board.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpp_board (
    input wire gpp_pkg::gpp_pad_t [7:0] pad_ctl, // pad controls
    input wire logic [7:0] ext_level, // weak outside level
    output logic [7:0] pad_in // resolved pin levels
);
    import gpp_pkg::*;
    // outside load is weak: any drive or pull of the port wins
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_ctl[i].oe)
                pad_in[i] = pad_ctl[i].out;
            else if (pad_ctl[i].pu)
                pad_in[i] = 1'b1;
            else if (pad_ctl[i].pd)
                pad_in[i] = 1'b0;
            else
                pad_in[i] = ext_level[i];
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb_gpp_port.sv ====
`timescale 1ns/1ps
`include "gpp_defs.svh"
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_gpp_port;
    import gpp_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0, ext = 0, pad_in;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, port_lvttl, usb_handover, port_irq, err;
    logic [15:0] aux_oe = 0;
    gpp_pad_t [7:0] pad_ctl;
    gpp_pad_t p;
    logic [5:0] got;
    int fail_count = 0, compares = 0;
    // {oe, driven high, pu, pd, ie, slow} per {code, out bit}
    localparam logic [5:0] ROWS [16] = '{6'h00, 6'h00, 6'h02, 6'h02,
        6'h22, 6'h0a, 6'h06, 6'h32, 6'h23, 6'h03, 6'h03, 6'h33, 6'h23,
        6'h33, 6'h06, 6'h0a};
    always #25 pclk = ~pclk;
    gpp_port #(.KIND(GPP_KIND_USB)) gpp_port_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
        .aux_oe(aux_oe), .pad_ctl(pad_ctl), .port_lvttl(port_lvttl),
        .usb_handover(usb_handover), .port_irq(port_irq)
    );
    gpp_board gpp_board_inst (
        .pad_ctl(pad_ctl), .ext_level(ext), .pad_in(pad_in)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // answer is taken at the rising edge that sees ready high
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic at_neg(input int k);
        repeat (k) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(50 * 6000);
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int i = 0; i < 16; i++) begin
            apb(1, `GPP_OFS_PINFORM, 32'(i) | 32'h10);
            apb(0, `GPP_OFS_DRVSEL2, 0);
            `CHK(rd[0], i[3])
            at_neg(0);
            p = pad_ctl[0];
            got = {p.oe, p.oe & p.out, p.pu, p.pd, p.ie, p.slow};
            `CHK(got, ROWS[i])
            @(posedge pclk);
        end
        done("drive codes");
        presetn <= 0;
        at_neg(1);
        `CHK(pad_ctl, 56'h0)
        @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, `GPP_OFS_PINFORM, 0);
        `CHK(rd[3:1], 3'h0)
        done("reset");
        apb(1, `GPP_OFS_DRVSEL0, 32'hff);
        apb(0, `GPP_OFS_DRVSEL0, 0);
        `CHK(rd[7:0], 8'h3f)
        apb(1, `GPP_OFS_PINFORM + 8'h1c, 32'h5);
        at_neg(1);
        `CHK({pad_ctl[7].oe, pad_ctl[7].pu, pad_ctl[7].ie}, 3'b011)
        @(posedge pclk);
        apb(1, `GPP_OFS_CTRL, 32'h3);
        at_neg(1);
        `CHK({port_lvttl, usb_handover, pad_ctl[7].pu}, 3'b110)
        @(posedge pclk);
        apb(1, `GPP_OFS_CTRL, 32'h0);
        done("usb pins");
        apb(1, `GPP_OFS_PINFORM + 8'h08, 32'h2d);
        apb(1, `GPP_OFS_OESEL, 32'h0000_0f00);
        at_neg(1);
        `CHK({pad_ctl[2].oe, pad_ctl[2].pu, pad_ctl[2].ie}, 3'b001)
        @(posedge pclk);
        aux_oe <= 16'h8000;
        at_neg(2);
        `CHK(pad_ctl[2].oe, 1'b1)
        @(posedge pclk);
        apb(1, `GPP_OFS_PINFORM + 8'h0c, 32'h4d);
        at_neg(1);
        `CHK({pad_ctl[3].oe, pad_ctl[3].ie}, 2'b10)
        `CHK(pad_ctl[3].slow, 1'b0)
        @(posedge pclk);
        apb(0, 8'h3c, 0);
        `CHK(err, 1'b1)
        done("bidir and disable");
        apb(1, `GPP_OFS_PINFORM + 8'h04, 32'h2);
        for (int t = 0; t < 4; t++) begin
            apb(1, `GPP_OFS_INTTYPE, 32'(t << 2));
            ext[1] <= 1;
            at_neg(6);
            `CHK(port_irq, t[0])
            @(posedge pclk);
            apb(0, `GPP_OFS_INTSTAT, 0);
            `CHK(rd[7:0], {6'h0, t[0], 1'b0})
            at_neg(2);
            `CHK(port_irq, 1'b0)
            @(posedge pclk);
            apb(0, `GPP_OFS_PINSTATE, 0);
            `CHK(rd[1], 1'b1)
            ext[1] <= 0;
            at_neg(6);
            @(posedge pclk);
            apb(0, `GPP_OFS_INTSTAT, 0);
            `CHK(rd[7:0], {6'h0, t[1], 1'b0})
        end
        done("pin interrupts");
        report_and_stop();
    end
endmodule
`default_nettype wire
